// ===== obc_option_byte_config_decoder.sv
// Purpose: Captures option bytes at reset and drives the decoded configuration.
// Assumes: Core clock mclk, active-low asynchronous reset rstn.
// Notes:   Programming access needs the programming pin high.
//
// Function
// - Halt entry resets when bit set, watchdog active.
// - Watchdog type: hardware always on, software enabled.
// - Clock guard enabled when its bit is zero.
// - Voltage field: off, lowest, medium, highest threshold.
// - Protection blocks flash access in test, programming.
// - Option erase under protection erases memory first.
// - Package bit: one large, zero small variant.
// - Unbonded pads reset as pulled-up inputs.
// - Reset phase 4096 or 256 cycles, also halt exit.
// - Oscillator field: resonator, reserved, RC, external.
// - Option bytes reachable only in programming mode.
// - Erased option bytes read as all ones.
// - Delivered flash parts use internal RC clock.
// - Mask parts use hard-wired factory values.
// - Range field selects resonator drive or frequency.
// - Doubler enabled at zero, bypassed at one.

`timescale 1ns/1ns
`default_nettype none

module obc_option_byte_config_decoder
    import obc_pkg::*;
#(
    parameter bit MASK_ROM = 1'b0
) (
    input  wire logic        mclk,
    input  wire logic        rstn,
    input  wire logic        nv_por_n,
    input  wire logic        in_circuit_programming,
    input  wire logic        test_mode,
    input  wire logic        prog_wr_en,
    input  wire logic        prog_rd_en,
    input  wire logic        prog_erase,
    input  wire logic        prog_byte_sel,
    input  wire logic [7:0]  prog_wdata,
    input  wire logic        user_mem_erase_done,
    input  wire logic        watchdog_type_sel_enable,
    input  wire logic        halt_entry,
    input  wire logic        halt_exit,
    output logic      [7:0]  prog_rdata_q,
    output logic             prog_busy_q,
    output logic             user_mem_erase_req_q,
    output logic             watchdog_enabled_q,
    output logic             halt_watchdog_reset_q,
    output logic             clock_guard_on_q,
    output logic             low_supply_detector_on_q,
    output logic             aux_supply_detector_on_q,
    output logic      [1:0]  voltage_detect_level_q,
    output logic             flash_access_block_q,
    output logic             package_select_q,
    output logic      [31:0] pad_pullup_lock_q,
    output logic             reset_delay_select_q,
    output logic             cpu_hold_q,
    output logic      [1:0]  osc_source_type_q,
    output logic             osc_reserved_sel_q,
    output logic      [2:0]  osc_freq_range_q,
    output logic             pll_doubler_on_q,
    output logic             cfg_valid_q
);

    // -------------------------------------------------------------------------
    // Option storage and field decode
    // -------------------------------------------------------------------------
    obc_opt_if opt ();

    obc_nv_store #(
        .MASK_ROM (MASK_ROM)
    ) u_store (
        .mclk     (mclk),
        .nv_por_n (nv_por_n),
        .opt      (opt.store)
    );

    obc_field_decode u_decode (
        .opt (opt.dec)
    );

    // -------------------------------------------------------------------------
    // Pin synchronisers
    // -------------------------------------------------------------------------
    logic icp_meta_q;
    logic icp_q;
    logic test_meta_q;
    logic test_q;

    // Programming and test mode pins come from outside the clock domain.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            icp_meta_q  <= 1'b0;
            icp_q       <= 1'b0;
            test_meta_q <= 1'b0;
            test_q      <= 1'b0;
        end else begin
            icp_meta_q  <= in_circuit_programming;
            icp_q       <= icp_meta_q;
            test_meta_q <= test_mode;
            test_q      <= test_meta_q;
        end
    end

    // -------------------------------------------------------------------------
    // Configuration capture
    // -------------------------------------------------------------------------
    logic     capture_pending_q;
    obc_cfg_t cfg_q;

    // The bytes are taken on the first edge after reset release and then held.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            capture_pending_q <= 1'b1;
            cfg_q             <= '1;
            cfg_valid_q       <= 1'b0;
        end else if (capture_pending_q) begin
            capture_pending_q <= 1'b0;
            cfg_q             <= opt.cfg;
            cfg_valid_q       <= 1'b1;
        end
    end

    // -------------------------------------------------------------------------
    // Programming port and erase sequencer
    // -------------------------------------------------------------------------
    obc_ers_t ers_state_q;
    logic     prog_ok;

    // Accesses from outside are honoured only in programming mode.
    assign prog_ok    = icp_q && (ers_state_q == OBC_IDLE);
    assign opt.sel    = prog_byte_sel;
    assign opt.wdata  = prog_wdata;
    // Reserved bits are stored as written.
    assign opt.wr_en  = prog_ok && prog_wr_en && !prog_erase;
    assign opt.erase_en = (ers_state_q == OBC_OPT_ERS);

    // Erase under live protection wipes user memory before the option bytes.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ers_state_q <= OBC_IDLE;
        end else begin
            unique case (ers_state_q)
                OBC_IDLE: begin
                    if (prog_ok && prog_erase) begin
                        if (!opt.cfg.prot_n) begin
                            ers_state_q <= OBC_MEM_ERS;
                        end else begin
                            ers_state_q <= OBC_OPT_ERS;
                        end
                    end
                end
                OBC_MEM_ERS: begin
                    if (user_mem_erase_done) begin
                        ers_state_q <= OBC_OPT_ERS;
                    end
                end
                OBC_OPT_ERS: begin
                    ers_state_q <= OBC_IDLE;
                end
                default: begin
                    ers_state_q <= OBC_IDLE;
                end
            endcase
        end
    end

    // Erase request to the user memory and busy flag for the programmer.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            user_mem_erase_req_q <= 1'b0;
            prog_busy_q          <= 1'b0;
        end else begin
            user_mem_erase_req_q <= (ers_state_q == OBC_IDLE) && prog_ok && prog_erase
                                    && !opt.cfg.prot_n;
            prog_busy_q          <= (ers_state_q != OBC_IDLE)
                                    || (prog_ok && prog_erase);
        end
    end

    // Read data: the stored byte in programming mode, zero otherwise.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            prog_rdata_q <= OB_READ_IDLE_VAL;
        end else if (prog_ok && prog_rd_en) begin
            prog_rdata_q <= prog_byte_sel ? opt.byte1 : opt.byte0;
        end else if (!icp_q) begin
            prog_rdata_q <= OB_READ_IDLE_VAL;
        end
    end

    // -------------------------------------------------------------------------
    // Watchdog and halt handling
    // -------------------------------------------------------------------------
    logic wdg_active;

    assign wdg_active = !cfg_q.watchdog_type_sel || watchdog_type_sel_enable;

    // Watchdog enable level and halt-entry reset pulse.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            watchdog_enabled_q    <= 1'b0;
            halt_watchdog_reset_q <= 1'b0;
        end else begin
            watchdog_enabled_q    <= cfg_valid_q && wdg_active;
            halt_watchdog_reset_q <= cfg_valid_q && halt_entry && wdg_active
                                     && cfg_q.halt_rst;
        end
    end

    // -------------------------------------------------------------------------
    // Clock guard, supply detection and protection
    // -------------------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            clock_guard_on_q         <= 1'b0;
            low_supply_detector_on_q <= 1'b0;
            aux_supply_detector_on_q <= 1'b0;
            voltage_detect_level_q   <= VD_OFF;
        end else begin
            clock_guard_on_q         <= cfg_valid_q && !cfg_q.guard_n;
            low_supply_detector_on_q <= cfg_valid_q && (cfg_q.vd_level != VD_OFF);
            aux_supply_detector_on_q <= cfg_valid_q && (cfg_q.vd_level != VD_OFF);
            voltage_detect_level_q   <= cfg_q.vd_level;
        end
    end

    // Flash access is blocked in test and programming modes when protected.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            flash_access_block_q <= 1'b1;
        end else begin
            flash_access_block_q <= !cfg_q.prot_n && (icp_q || test_q);
        end
    end

    // -------------------------------------------------------------------------
    // Package and unbonded pads
    // -------------------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            package_select_q <= 1'b1;
        end else begin
            package_select_q <= cfg_q.pkg;
        end
    end

    // Each pad left unbonded in the small package is locked as pulled-up input.
    genvar pad;
    generate
        for (pad = 0; pad < PAD_COUNT; pad++) begin : g_pad
            always_ff @(posedge mclk or negedge rstn) begin
                if (!rstn) begin
                    pad_pullup_lock_q[pad] <= 1'b1;
                end else begin
                    pad_pullup_lock_q[pad] <= !cfg_q.pkg
                                              && SMALL_PKG_UNBONDED[pad];
                end
            end
        end
    endgenerate

    // -------------------------------------------------------------------------
    // Reset phase and halt exit delay
    // -------------------------------------------------------------------------
    logic [RST_CNT_W-1:0] dly_cnt_q;
    logic [RST_CNT_W-1:0] dly_len;

    // Long phase suits resonators.
    assign dly_len   = cfg_q.reset_delay_select ? RST_CNT_W'(RST_SHORT_CYC) : RST_CNT_W'(RST_LONG_CYC);

    // The CPU is held for the selected count after reset and after halt exit.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            dly_cnt_q  <= '0;
            cpu_hold_q <= 1'b1;
        end else if (capture_pending_q || (cfg_valid_q && halt_exit)) begin
            dly_cnt_q  <= '0;
            cpu_hold_q <= 1'b1;
        end else if (cpu_hold_q) begin
            if (dly_cnt_q == dly_len - RST_CNT_W'(1)) begin
                cpu_hold_q <= 1'b0;
            end else begin
                dly_cnt_q <= dly_cnt_q + RST_CNT_W'(1);
            end
        end
    end

    // -------------------------------------------------------------------------
    // Clock source selection
    // -------------------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            reset_delay_select_q <= 1'b0;
            osc_source_type_q    <= OSC_RC;
            osc_reserved_sel_q   <= 1'b0;
            osc_freq_range_q     <= '1;
            pll_doubler_on_q     <= 1'b0;
        end else begin
            reset_delay_select_q <= cfg_q.reset_delay_select;
            osc_source_type_q    <= cfg_q.osc_type;
            osc_reserved_sel_q   <= (cfg_q.osc_type == OSC_RESERVED);
            osc_freq_range_q     <= cfg_q.osc_range;
            // Range misuse is the configurer's fault.
            pll_doubler_on_q     <= cfg_valid_q && !cfg_q.pll_off;
        end
    end

endmodule : obc_option_byte_config_decoder

`default_nettype wire

// ===== obc_pkg.sv
// Purpose: Shared constants and types for the option byte configuration decoder.
// Assumes: Two 8-bit option bytes, core clock domain only.
// Notes:   Bit positions, delivered values and cycle counts live here; the assertions and bench repeat some as literals.

package obc_pkg;

    // -------------------------------------------------------------------------
    // Option byte zero field positions
    // -------------------------------------------------------------------------
    localparam int unsigned OB0_HALT_RST_BIT = 7;
    localparam int unsigned OB0_WDG_TYPE_BIT = 6;
    localparam int unsigned OB0_GUARD_N_BIT  = 5;
    localparam int unsigned OB0_VD_HI_BIT    = 4;
    localparam int unsigned OB0_VD_LO_BIT    = 3;
    localparam int unsigned OB0_PROT_N_BIT   = 0;

    // -------------------------------------------------------------------------
    // Option byte one field positions
    // -------------------------------------------------------------------------
    localparam int unsigned OB1_PKG_BIT      = 7;
    localparam int unsigned OB1_RESET_DELAY_SELECT_BIT     = 6;
    localparam int unsigned OB1_OSC_HI_BIT   = 5;
    localparam int unsigned OB1_OSC_LO_BIT   = 4;
    localparam int unsigned OB1_RANGE_HI_BIT = 3;
    localparam int unsigned OB1_RANGE_LO_BIT = 1;
    localparam int unsigned OB1_PLL_OFF_BIT  = 0;

    // -------------------------------------------------------------------------
    // Stored values
    // -------------------------------------------------------------------------
    localparam logic [7:0] OB_ERASED_VAL    = 8'hFF;
    localparam logic [7:0] OB0_DELIVER_VAL  = 8'hE7;
    localparam logic [7:0] OB1_DELIVER_VAL  = 8'hEF;
    localparam logic [7:0] OB0_FACTORY_VAL  = 8'hE7;
    localparam logic [7:0] OB1_FACTORY_VAL  = 8'hEF;
    localparam logic [7:0] OB_READ_IDLE_VAL = 8'h00;

    // -------------------------------------------------------------------------
    // Encodings
    // -------------------------------------------------------------------------
    localparam logic [1:0] VD_OFF       = 2'h3;
    localparam logic [1:0] VD_LOWEST    = 2'h2;
    localparam logic [1:0] VD_MEDIUM    = 2'h1;
    localparam logic [1:0] VD_HIGHEST   = 2'h0;
    localparam logic [1:0] OSC_RESON    = 2'h0;
    localparam logic [1:0] OSC_RESERVED = 2'h1;
    localparam logic [1:0] OSC_RC       = 2'h2;
    localparam logic [1:0] OSC_EXT      = 2'h3;
    localparam logic [2:0] RANGE_2_4MHZ = 3'h1;

    // -------------------------------------------------------------------------
    // Reset phase lengths and pads
    // -------------------------------------------------------------------------
    localparam int unsigned RST_LONG_CYC  = 4096;
    localparam int unsigned RST_SHORT_CYC = 256;
    localparam int unsigned RST_CNT_W     = 13;
    localparam int unsigned PADS_PER_PORT = 8;
    localparam int unsigned PORT_COUNT    = 4;
    localparam int unsigned PAD_COUNT     = PADS_PER_PORT * PORT_COUNT;
    localparam logic [31:0] SMALL_PKG_UNBONDED = 32'hFF00_0000;

    // Decoded configuration carried from the field decoder.
    typedef struct packed {
        logic       halt_rst;
        logic       watchdog_type_sel;
        logic       guard_n;
        logic [1:0] vd_level;
        logic       prot_n;
        logic       pkg;
        logic       reset_delay_select;
        logic [1:0] osc_type;
        logic [2:0] osc_range;
        logic       pll_off;
    } obc_cfg_t;

    // Erase sequencer states.
    typedef enum logic [1:0] {
        OBC_IDLE    = 2'b00,
        OBC_MEM_ERS = 2'b01,
        OBC_OPT_ERS = 2'b10
    } obc_ers_t;

endpackage : obc_pkg

// ===== obc_opt_if.sv
// Purpose: Option bytes, store commands and decoded fields.
// Assumes: All signals in the mclk domain.
// Notes:   Three parties: the store, the field decoder and the controller.

`timescale 1ns/1ns
`default_nettype none

interface obc_opt_if;
    import obc_pkg::*;

    logic [7:0] byte0;
    logic [7:0] byte1;
    logic       wr_en;
    logic       erase_en;
    logic       sel;
    logic [7:0] wdata;
    obc_cfg_t   cfg;

    modport store (input wr_en, erase_en, sel, wdata, output byte0, byte1);
    modport dec   (input byte0, byte1, output cfg);
    modport ctrl  (output wr_en, erase_en, sel, wdata, input byte0, byte1, cfg);
endinterface : obc_opt_if

`default_nettype wire

// ===== obc_nv_store.sv
// Purpose: Holds the two option bytes, or the factory values on mask parts.
// Assumes: nv_por_n is not the system reset.
// Notes:   System reset leaves the stored bytes untouched.

`timescale 1ns/1ns
`default_nettype none

module obc_nv_store
    import obc_pkg::*;
#(
    parameter bit MASK_ROM = 1'b0
) (
    input  wire logic  mclk,
    input  wire logic  nv_por_n,
    obc_opt_if.store   opt
);

    logic [7:0] byte0_q;
    logic [7:0] byte1_q;

    // Delivered parts start with the internal RC source; erase writes all ones.
    always_ff @(posedge mclk or negedge nv_por_n) begin
        if (!nv_por_n) begin
            byte0_q <= OB0_DELIVER_VAL;
            byte1_q <= OB1_DELIVER_VAL;
        end else if (opt.erase_en) begin
            byte0_q <= OB_ERASED_VAL;
            byte1_q <= OB_ERASED_VAL;
        end else if (opt.wr_en && !opt.sel) begin
            byte0_q <= opt.wdata;
        end else if (opt.wr_en && opt.sel) begin
            byte1_q <= opt.wdata;
        end
    end

    // Mask parts ignore the stored bytes and present the factory code.
    assign opt.byte0 = MASK_ROM ? OB0_FACTORY_VAL : byte0_q;
    assign opt.byte1 = MASK_ROM ? OB1_FACTORY_VAL : byte1_q;

endmodule : obc_nv_store

`default_nettype wire

// ===== obc_field_decode.sv
// Purpose: Splits the two option bytes into named configuration fields.
// Assumes: Stable bytes.
// Notes:   Combinational only.

`timescale 1ns/1ns
`default_nettype none

module obc_field_decode
    import obc_pkg::*;
(
    obc_opt_if.dec opt
);

    // Field extraction from both bytes.
    always_comb begin
        opt.cfg.halt_rst  = opt.byte0[OB0_HALT_RST_BIT];
        opt.cfg.watchdog_type_sel    = opt.byte0[OB0_WDG_TYPE_BIT];
        opt.cfg.guard_n   = opt.byte0[OB0_GUARD_N_BIT];
        opt.cfg.vd_level  = opt.byte0[OB0_VD_HI_BIT:OB0_VD_LO_BIT];
        opt.cfg.prot_n    = opt.byte0[OB0_PROT_N_BIT];
        opt.cfg.pkg       = opt.byte1[OB1_PKG_BIT];
        opt.cfg.reset_delay_select      = opt.byte1[OB1_RESET_DELAY_SELECT_BIT];
        opt.cfg.osc_type  = opt.byte1[OB1_OSC_HI_BIT:OB1_OSC_LO_BIT];
        opt.cfg.osc_range = opt.byte1[OB1_RANGE_HI_BIT:OB1_RANGE_LO_BIT];
        opt.cfg.pll_off   = opt.byte1[OB1_PLL_OFF_BIT];
    end

endmodule : obc_field_decode

`default_nettype wire

// ===== obc_cfg_assertions.sv
// Purpose: Port assertions for the decoder.
// Assumes: One mclk domain.
// Notes:   Bound from the testbench top file.
`timescale 1ns/1ns
`default_nettype none
module obc_cfg_assertions (
    input wire logic       mclk,
    input wire logic       rstn,
    input wire logic       in_circuit_programming,
    input wire logic       halt_entry,
    input wire logic [7:0] prog_rdata_q,
    input wire logic       prog_busy_q,
    input wire logic       user_mem_erase_req_q,
    input wire logic       watchdog_enabled_q,
    input wire logic       halt_watchdog_reset_q,
    input wire logic       low_supply_detector_on_q,
    input wire logic       aux_supply_detector_on_q,
    input wire logic [1:0] voltage_detect_level_q,
    input wire logic       reset_delay_select_q,
    input wire logic       cpu_hold_q,
    input wire logic [1:0] osc_source_type_q,
    input wire logic       osc_reserved_sel_q,
    input wire logic       cfg_valid_q
);
    logic [12:0] hold_cnt_q;
    // Counts hold cycles, saturating.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) hold_cnt_q <= 13'h0000;
        else if (!cpu_hold_q) hold_cnt_q <= 13'h0000;
        else if (hold_cnt_q != 13'h1FFF) hold_cnt_q <= hold_cnt_q + 13'h0001;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    a_detect_pair_on: assert property ($past(cfg_valid_q, 2) |-> low_supply_detector_on_q ==
        aux_supply_detector_on_q && low_supply_detector_on_q == (voltage_detect_level_q != 2'h3))
        else $error("detector mismatch");
    a_cfg_held: assert property ($past(cfg_valid_q, 3) |-> $stable(osc_source_type_q) &&
        $stable(voltage_detect_level_q)) else $error("config changed");
    a_osc_reserved_flag: assert property ($past(cfg_valid_q, 2) |->
        osc_reserved_sel_q == (osc_source_type_q == 2'h1)) else $error("reserved flag wrong");
    a_halt_reset_cause: assert property (halt_watchdog_reset_q |->
        $past(halt_entry) && $past(watchdog_enabled_q)) else $error("stray halt reset");
    a_rdata_idle: assert property (!in_circuit_programming [*5] |->
        prog_rdata_q == 8'h00) else $error("read data outside programming mode");
    a_erase_req_pulse: assert property (user_mem_erase_req_q |=>
        !user_mem_erase_req_q) else $error("erase request too long");
    a_erase_req_busy: assert property (user_mem_erase_req_q |-> prog_busy_q)
        else $error("erase without busy");
    a_hold_length: assert property ($fell(cpu_hold_q) |-> hold_cnt_q >=
        (reset_delay_select_q ? 13'h00FF : 13'h0FFF)) else $error("hold phase too short");
endmodule : obc_cfg_assertions
`default_nettype wire

// ===== obc_flash_model.sv
// Purpose: User flash erase model.
// Assumes: Single-cycle requests.
// Notes:   Answers after DLY cycles.
`timescale 1ns/1ns
`default_nettype none
module obc_flash_model #(
    parameter int DLY = 5
) (
    input  wire logic       mclk,
    input  wire logic       rstn,
    input  wire logic       erase_req,
    output var  logic       erase_done,
    output var  logic [7:0] req_count
);
    int cnt;
    // One done pulse per request.
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            erase_done <= 1'b0;
            req_count <= 8'h00;
            cnt <= 0;
        end else if (erase_req) begin
            cnt <= DLY;
            req_count <= req_count + 8'h01;
            erase_done <= 1'b0;
        end else begin
            cnt <= (cnt > 0) ? cnt - 1 : 0;
            erase_done <= (cnt == 1);
        end
    end
endmodule : obc_flash_model
`default_nettype wire

// ===== obc_option_byte_config_decoder_tb.sv
// Purpose: Self-checking decoder bench.
// Assumes: 25 MHz mclk.
// Notes:   Each pair is written, reset in and checked.
`timescale 1ns/1ns
`default_nettype none
module obc_option_byte_config_decoder_tb;
    import obc_pkg::*;
    logic mclk = 1'b0, rstn, nv_por_n, in_circuit_programming, test_mode, watchdog_type_sel_enable;
    logic prog_wr_en, prog_rd_en, prog_erase, prog_byte_sel, halt_entry, halt_exit;
    logic prog_busy_q, erase_req, erase_done, watchdog_enabled_q, halt_watchdog_reset_q;
    logic clock_guard_on_q, low_supply_detector_on_q, aux_supply_detector_on_q;
    logic flash_access_block_q, package_select_q, reset_delay_select_q, cpu_hold_q;
    logic osc_reserved_sel_q, pll_doubler_on_q, cfg_valid_q;
    logic [7:0]  prog_wdata, prog_rdata_q, req_count, b0, b1;
    logic [1:0]  voltage_detect_level_q, osc_source_type_q, prev;
    logic [2:0]  osc_freq_range_q;
    logic [31:0] pad_pullup_lock_q;
    // Reserved bits 11, resonators long, doubler at 2-4 MHz.
    logic [15:0] cfgs [4] = '{16'h4612, 16'h8FB7, 16'hFF01, 16'hD7E2};
    int errors = 0, n_compared = 0, hold, k;
    always #20 mclk = ~mclk;
    obc_option_byte_config_decoder u_dut (.mclk, .rstn, .nv_por_n, .in_circuit_programming,
        .test_mode, .prog_wr_en, .prog_rd_en, .prog_erase, .prog_byte_sel, .prog_wdata,
        .user_mem_erase_done(erase_done), .watchdog_type_sel_enable, .halt_entry, .halt_exit,
        .prog_rdata_q, .prog_busy_q, .user_mem_erase_req_q(erase_req), .watchdog_enabled_q,
        .halt_watchdog_reset_q, .clock_guard_on_q, .low_supply_detector_on_q,
        .aux_supply_detector_on_q, .voltage_detect_level_q, .flash_access_block_q,
        .package_select_q, .pad_pullup_lock_q, .reset_delay_select_q, .cpu_hold_q,
        .osc_source_type_q, .osc_reserved_sel_q, .osc_freq_range_q, .pll_doubler_on_q,
        .cfg_valid_q);
    obc_flash_model u_flash (.mclk, .rstn(nv_por_n), .erase_req, .erase_done, .req_count);
    task automatic give_verdict();
        $display("compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %0t: %h not %h", $time, seen, exp);
        end
    endtask : chk
    // One strobe cycle: s is {halt_exit, halt_entry, erase, read, write}.
    task automatic go(input logic [4:0] s, input logic sel, input logic [7:0] d);
        @(posedge mclk);
        {halt_exit, halt_entry, prog_erase, prog_rd_en, prog_wr_en} <= s;
        prog_byte_sel <= sel;
        prog_wdata <= d;
        @(posedge mclk);
        {halt_exit, halt_entry, prog_erase, prog_rd_en, prog_wr_en} <= 5'h00;
        #1;
    endtask : go
    task automatic do_rst(output int n);
        rstn <= 1'b0;
        repeat (16) @(posedge mclk);
        rstn <= 1'b1;
        for (n = 0; n < 5000 && cpu_hold_q !== 1'b0; n++) @(posedge mclk) #1;
        if (n == 5000) begin
            errors++;
            give_verdict();
        end
    endtask : do_rst
    task automatic wait_idle();
        int i;
        for (i = 0; i < 200 && prog_busy_q !== 1'b0; i++) @(posedge mclk) #1;
        if (i == 200) begin
            errors++;
            give_verdict();
        end
    endtask : wait_idle
    initial begin
        {rstn, nv_por_n, in_circuit_programming, test_mode, watchdog_type_sel_enable} = 5'h00;
        {prog_wr_en, prog_rd_en, prog_erase, prog_byte_sel, halt_entry, halt_exit} = 6'h00;
        prog_wdata = 8'h00;
        @(posedge mclk) nv_por_n <= 1'b1;
        in_circuit_programming <= 1'b1;
        do_rst(hold);
        chk(osc_source_type_q, OSC_RC);
        go(5'h02, 1'b0, 8'h00);
        chk(prog_rdata_q, OB0_DELIVER_VAL);
        for (k = 0; k < 4; k++) begin
            {b0, b1} = cfgs[k];
            go(5'h01, 1'b0, b0);
            go(5'h01, 1'b1, b1);
            if (k > 0) chk(osc_source_type_q, prev);
            do_rst(hold);
            chk(hold >= (b1[6] ? 256 : 4096) && hold <= (b1[6] ? 260 : 4100), 1'b1);
            chk({watchdog_enabled_q, clock_guard_on_q}, {!b0[6], !b0[5]});
            chk({voltage_detect_level_q, low_supply_detector_on_q, aux_supply_detector_on_q},
                {b0[4:3], {2{b0[4:3] != 2'h3}}});
            chk(flash_access_block_q, !b0[0]);
            chk({package_select_q, pad_pullup_lock_q},
                {b1[7], b1[7] ? 32'h0000_0000 : SMALL_PKG_UNBONDED});
            chk({reset_delay_select_q, osc_source_type_q, osc_reserved_sel_q},
                {b1[6:4], b1[5:4] == OSC_RESERVED});
            chk({osc_freq_range_q, pll_doubler_on_q}, {b1[3:1], !b1[0]});
            @(posedge mclk) watchdog_type_sel_enable <= 1'b1;
            repeat (3) @(posedge mclk);
            #1 chk(watchdog_enabled_q, 1'b1);
            go(5'h08, 1'b0, 8'h00);
            chk(halt_watchdog_reset_q, b0[7]);
            @(posedge mclk) watchdog_type_sel_enable <= 1'b0;
            go(5'h08, 1'b0, 8'h00);
            chk(halt_watchdog_reset_q, b0[7] & !b0[6]);
            go(5'h10, 1'b0, 8'h00);
            #40 chk(cpu_hold_q, 1'b1);
            prev = b1[5:4];
        end
        @(posedge mclk) in_circuit_programming <= 1'b0;
        repeat (4) @(posedge mclk);
        go(5'h02, 1'b1, 8'h00);
        chk(prog_rdata_q, 8'h00);
        go(5'h01, 1'b1, 8'h00);
        @(posedge mclk) in_circuit_programming <= 1'b1;
        repeat (4) @(posedge mclk);
        go(5'h02, 1'b1, 8'h00);
        chk(prog_rdata_q, b1);
        go(5'h01, 1'b0, 8'h06);
        repeat (3) @(posedge mclk);
        #1 chk(flash_access_block_q, 1'b0);
        for (k = 0; k < 2; k++) begin
            go(5'h04, 1'b0, 8'h00);
            wait_idle();
            chk(req_count, 8'h01);
        end
        go(5'h02, 1'b1, 8'h00);
        chk(prog_rdata_q, OB_ERASED_VAL);
        give_verdict();
    end
endmodule : obc_option_byte_config_decoder_tb
bind obc_option_byte_config_decoder obc_cfg_assertions u_chk (.mclk, .rstn,
    .in_circuit_programming, .halt_entry, .prog_rdata_q, .prog_busy_q, .user_mem_erase_req_q,
    .watchdog_enabled_q, .halt_watchdog_reset_q, .low_supply_detector_on_q,
    .aux_supply_detector_on_q, .voltage_detect_level_q, .reset_delay_select_q, .cpu_hold_q,
    .osc_source_type_q, .osc_reserved_sel_q, .cfg_valid_q);
`default_nettype wire
